// ==== src/ppr_top.sv ====
`timescale 1ns/10ps
module ppr_top (
	// clock and reset
	input  wire logic                            clk_in,
	input  wire logic                            rst_in,
	// apb slave
	input  wire logic                            psel_in,
	input  wire logic                            penable_in,
	input  wire logic                            pwrite_in,
	input  wire logic [ppr_pkg::ADDR_W-1:0]      paddr_in,
	input  wire logic [ppr_pkg::DATA_W-1:0]      pwdata_in,
	output logic      [ppr_pkg::DATA_W-1:0]      prdata_out,
	output logic                                 pready_out,
	output logic                                 pslverr_out,
	// port A pins
	input  wire logic [ppr_pkg::PA_W-1:0]        pa_pin_in,
	output logic      [ppr_pkg::PA_W-1:0]        pa_pin_out,
	output logic      [ppr_pkg::PA_W-1:0]        pa_pin_oe_out,
	output logic      [ppr_pkg::PA_W-1:0]        pa_pullup_out,
	output logic      [ppr_pkg::PA_W-1:0]        keypad_inputs_out,
	// port C and D pad controls
	output logic      [ppr_pkg::PC_W-1:0]        pc_dir_out,
	output logic      [ppr_pkg::PC_W-1:0]        pc_pullup_out,
	output logic      [ppr_pkg::PD_W-1:0]        pd_dir_out,
	output logic      [ppr_pkg::PD_W-1:0]        pd_pullup_out,
	// port E pins and sharing peripheral
	input  wire logic [ppr_pkg::PE_W-1:0]        pe_pin_in,
	output logic      [ppr_pkg::PE_W-1:0]        pe_pin_out,
	output logic      [ppr_pkg::PE_W-1:0]        pe_pin_oe_out,
	input  wire logic                            pe_periph_en_in,
	input  wire logic [ppr_pkg::PE_W-1:0]        pe_periph_oe_in,
	input  wire logic [ppr_pkg::PE_W-1:0]        pe_periph_do_in
);

	ppr_pkg::ppr_state_t st_q;
	ppr_pkg::ppr_state_t st_d;

	logic                       setup_w;
	logic                       wr_w;
	logic [ppr_pkg::ADDR_W-1:0] idx_w;
	logic [7:0]                 rd_byte;
	logic                       hit;
	logic [7:0]                 pe_view;

	// mixes latch and pin per bit by direction
	function automatic logic [7:0] pin_view(input logic [7:0] dir, input logic [7:0] lat,
						input logic [7:0] pin);
		pin_view = (dir & lat) | (~dir & pin);
	endfunction

	// apb phase decode
	assign setup_w = psel_in & ~penable_in;
	assign wr_w    = psel_in & penable_in & pwrite_in & st_q.pready;
	assign idx_w   = paddr_in >> ppr_pkg::WORD_SHIFT;

	// port E read view, latch or pin per bit
	assign pe_view = pin_view({6'h00, st_q.pe_dir}, {6'h00, st_q.pe_latch},
				  {6'h00, st_q.pe_smp});

	// read mux for the addressed register
	always_comb begin
		rd_byte = 8'h00;
		hit     = 1'b1;
		case (idx_w)
			ppr_pkg::IDX_PA_LATCH: rd_byte = pin_view(st_q.pa_dir, st_q.pa_latch,
								  st_q.pa_smp);
			ppr_pkg::IDX_PC_DIR:   rd_byte = {1'b0, st_q.pc_dir};
			ppr_pkg::IDX_PD_DIR:   rd_byte = st_q.pd_dir;
			ppr_pkg::IDX_PE_LATCH: rd_byte = {6'h00, pe_view[1:0]};
			ppr_pkg::IDX_PE_DIR:   rd_byte = {6'h00, st_q.pe_dir};
			ppr_pkg::IDX_PA_PUE:   rd_byte = st_q.pa_pue;
			ppr_pkg::IDX_PC_PUE:   rd_byte = {1'b0, st_q.pc_pue};
			ppr_pkg::IDX_PD_PUE:   rd_byte = st_q.pd_pue;
			ppr_pkg::IDX_PA_DIR:   rd_byte = st_q.pa_dir;
			ppr_pkg::IDX_KBI_CTL:  rd_byte = st_q.kbi_en;
			default:               hit     = 1'b0;
		endcase
	end

	// next state of the whole block
	always_comb begin
		st_d = st_q;
		// pin sampling
		st_d.pa_smp = pa_pin_in;
		st_d.pe_smp = pe_pin_in;
		// bus answer: data captured in setup, ready in access
		st_d.pready  = setup_w;
		st_d.pslverr = setup_w & ~hit;
		if (setup_w) begin
			st_d.prdata = {24'h000000, rd_byte};
		end
		// register writes
		if (wr_w) begin
			case (idx_w)
				ppr_pkg::IDX_PA_LATCH: st_d.pa_latch = pwdata_in[7:0];
				ppr_pkg::IDX_PC_DIR:   st_d.pc_dir   = pwdata_in[6:0];
				ppr_pkg::IDX_PD_DIR:   st_d.pd_dir   = pwdata_in[7:0];
				ppr_pkg::IDX_PE_LATCH: st_d.pe_latch = pwdata_in[1:0];
				ppr_pkg::IDX_PE_DIR:   st_d.pe_dir   = pwdata_in[1:0];
				ppr_pkg::IDX_PA_PUE:   st_d.pa_pue   = pwdata_in[7:0];
				ppr_pkg::IDX_PC_PUE:   st_d.pc_pue   = pwdata_in[6:0];
				ppr_pkg::IDX_PD_PUE:   st_d.pd_pue   = pwdata_in[7:0];
				ppr_pkg::IDX_PA_DIR:   st_d.pa_dir   = pwdata_in[7:0];
				ppr_pkg::IDX_KBI_CTL:  st_d.kbi_en   = pwdata_in[7:0];
				default:               st_d.pslverr  = 1'b0;
			endcase
		end
		// reset: latches are left alone on purpose
		if (rst_in) begin
			st_d.pa_dir  = ppr_pkg::DIR_RST;
			st_d.pa_pue  = ppr_pkg::PUE_RST;
			st_d.kbi_en  = ppr_pkg::KBI_RST;
			st_d.pc_dir  = ppr_pkg::DIR_RST[6:0];
			st_d.pc_pue  = ppr_pkg::PUE_RST[6:0];
			st_d.pd_dir  = ppr_pkg::DIR_RST;
			st_d.pd_pue  = ppr_pkg::PUE_RST;
			st_d.pe_dir  = ppr_pkg::DIR_RST[1:0];
			st_d.prdata  = 32'h00000000;
			st_d.pready  = 1'b0;
			st_d.pslverr = 1'b0;
		end
		// pad controls; keypad enable forces the pin to input
		st_d.pa_oe = st_d.pa_dir & ~st_d.kbi_en;
		st_d.pa_do = st_d.pa_latch & st_d.pa_oe;
		st_d.pa_pu = st_d.pa_pue & (~st_d.pa_dir | st_d.kbi_en);
		st_d.kbd   = st_d.pa_smp & st_d.kbi_en;
		st_d.pc_pu = st_d.pc_pue & ~st_d.pc_dir;
		st_d.pd_pu = st_d.pd_pue & ~st_d.pd_dir;
		// serial peripheral owns port E when enabled
		st_d.pe_oe = pe_periph_en_in ? pe_periph_oe_in : st_d.pe_dir;
		st_d.pe_do = pe_periph_en_in ? pe_periph_do_in : st_d.pe_latch;
	end

	// state register
	always_ff @(posedge clk_in) begin
		st_q <= st_d;
	end

	// outputs straight from the state register
	assign prdata_out        = st_q.prdata;
	assign pready_out        = st_q.pready;
	assign pslverr_out       = st_q.pslverr;
	assign pa_pin_out        = st_q.pa_do;
	assign pa_pin_oe_out     = st_q.pa_oe;
	assign pa_pullup_out     = st_q.pa_pu;
	assign keypad_inputs_out = st_q.kbd;
	assign pc_dir_out        = st_q.pc_dir;
	assign pc_pullup_out     = st_q.pc_pu;
	assign pd_dir_out        = st_q.pd_dir;
	assign pd_pullup_out     = st_q.pd_pu;
	assign pe_pin_out        = st_q.pe_do;
	assign pe_pin_oe_out     = st_q.pe_oe;

	// checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	AST_OE_FOLLOWS_DIR: assert property (
		pa_pin_oe_out == (st_q.pa_dir & ~st_q.kbi_en) &&
		pa_pin_out == (st_q.pa_latch & pa_pin_oe_out))
		else $error("port A drive does not follow direction and latch");

	AST_RESET_DIR: assert property (@(posedge clk_in) disable iff (1'b0)
		rst_in |=> st_q.pa_dir == ppr_pkg::DIR_RST && pa_pin_oe_out == ppr_pkg::DIR_RST)
		else $error("port A directions not cleared by reset");

	AST_RESET_KEEPS_LATCH: assert property (@(posedge clk_in) disable iff (1'b0)
		rst_in && !$past(rst_in) |=> st_q.pa_latch == $past(st_q.pa_latch))
		else $error("reset changed port A latch");

	AST_READ_VIEW: assert property (
		setup_w && idx_w == 8'h00 |=> prdata_out[7:0] ==
		(($past(st_q.pa_dir) & $past(st_q.pa_latch)) | (~$past(st_q.pa_dir) & $past(st_q.pa_smp))))
		else $error("port A read mixes latch and pin wrongly");

	AST_READ_PIN: assert property (
		setup_w && idx_w == 8'h00 && st_q.pa_dir == 8'h00 ##1 1'b1 ##1 1'b1
		|-> prdata_out[7:0] == $past(pa_pin_in, 3))
		else $error("input pin read is not the sampled level");

	AST_LATCH_WRITE: assert property (
		wr_w && idx_w == 8'h00 |=> st_q.pa_latch == $past(pwdata_in[7:0]))
		else $error("port A latch write lost");

	AST_PULLUP: assert property (
		pa_pullup_out == (st_q.pa_pue & (~st_q.pa_dir | st_q.kbi_en)))
		else $error("port A pullup control wrong");

	AST_PULLUP_OFF_OUT: assert property (
		((pc_pullup_out & pc_dir_out) == 7'h00) && ((pd_pullup_out & pd_dir_out) == 8'h00))
		else $error("pullup left on for an output pin");

	AST_KBD: assert property (
		keypad_inputs_out == ($past(pa_pin_in) & st_q.kbi_en))
		else $error("keypad input not gated by its enable");

	AST_PE_OVERRIDE: assert property (
		pe_periph_en_in |=> pe_pin_oe_out == $past(pe_periph_oe_in) &&
		pe_pin_out == $past(pe_periph_do_in))
		else $error("peripheral does not own port E");

	AST_READY_ONE_CYCLE: assert property (
		setup_w |=> pready_out ##1 !pready_out || setup_w)
		else $error("apb ready not a single access cycle");

	AST_PA_DIR_WRITE: assert property (
		wr_w && idx_w == ppr_pkg::IDX_PA_DIR
		|=> st_q.pa_dir == $past(pwdata_in[7:0]))
		else $error("port A direction write lost");

	AST_PC_DIR_WRITE: assert property (
		wr_w && idx_w == ppr_pkg::IDX_PC_DIR
		|=> pc_dir_out == $past(pwdata_in[6:0]))
		else $error("port C direction write lost");

	AST_PD_DIR_WRITE: assert property (
		wr_w && idx_w == ppr_pkg::IDX_PD_DIR
		|=> pd_dir_out == $past(pwdata_in[7:0]))
		else $error("port D direction write lost");

	AST_PE_LATCH_WRITE: assert property (
		wr_w && idx_w == ppr_pkg::IDX_PE_LATCH
		|=> st_q.pe_latch == $past(pwdata_in[1:0]))
		else $error("port E latch write lost");

	AST_PE_DIR_WRITE: assert property (
		wr_w && idx_w == ppr_pkg::IDX_PE_DIR
		|=> st_q.pe_dir == $past(pwdata_in[1:0]))
		else $error("port E direction write lost");

	AST_PA_PUE_WRITE: assert property (
		wr_w && idx_w == ppr_pkg::IDX_PA_PUE
		|=> st_q.pa_pue == $past(pwdata_in[7:0]))
		else $error("port A pullup enable write lost");

	AST_PC_PUE_WRITE: assert property (
		wr_w && idx_w == ppr_pkg::IDX_PC_PUE
		|=> st_q.pc_pue == $past(pwdata_in[6:0]))
		else $error("port C pullup enable write lost");

	AST_PD_PUE_WRITE: assert property (
		wr_w && idx_w == ppr_pkg::IDX_PD_PUE
		|=> st_q.pd_pue == $past(pwdata_in[7:0]))
		else $error("port D pullup enable write lost");

	AST_KBI_WRITE: assert property (
		wr_w && idx_w == ppr_pkg::IDX_KBI_CTL
		|=> st_q.kbi_en == $past(pwdata_in[7:0]))
		else $error("keypad enable write lost");

	AST_RESET_PC_DIR: assert property (@(posedge clk_in) disable iff (1'b0)
		rst_in |=> pc_dir_out == ppr_pkg::DIR_RST[6:0] &&
		pc_pullup_out == ppr_pkg::PUE_RST[6:0])
		else $error("port C direction not cleared by reset");

	AST_RESET_PD_DIR: assert property (@(posedge clk_in) disable iff (1'b0)
		rst_in |=> pd_dir_out == ppr_pkg::DIR_RST &&
		pd_pullup_out == ppr_pkg::PUE_RST)
		else $error("port D direction not cleared by reset");

	AST_RESET_PE_DIR: assert property (@(posedge clk_in) disable iff (1'b0)
		rst_in && !pe_periph_en_in |=> st_q.pe_dir == ppr_pkg::DIR_RST[1:0] &&
		pe_pin_oe_out == ppr_pkg::DIR_RST[1:0])
		else $error("port E direction not cleared by reset");

	AST_RESET_PA_PUE: assert property (@(posedge clk_in) disable iff (1'b0)
		rst_in |=> st_q.pa_pue == ppr_pkg::PUE_RST &&
		pa_pullup_out == ppr_pkg::PUE_RST)
		else $error("port A pullup enables not cleared by reset");

	AST_RESET_PC_PUE: assert property (@(posedge clk_in) disable iff (1'b0)
		rst_in
		|=> st_q.pc_pue == ppr_pkg::PUE_RST[6:0])
		else $error("port C pullup enables not cleared by reset");

	AST_RESET_PD_PUE: assert property (@(posedge clk_in) disable iff (1'b0)
		rst_in
		|=> st_q.pd_pue == ppr_pkg::PUE_RST)
		else $error("port D pullup enables not cleared by reset");

	AST_RESET_KBI: assert property (@(posedge clk_in) disable iff (1'b0)
		rst_in |=> st_q.kbi_en == ppr_pkg::KBI_RST &&
		keypad_inputs_out == ppr_pkg::KBI_RST)
		else $error("keypad enables not cleared by reset");

	AST_RESET_KEEPS_PE_LATCH: assert property (@(posedge clk_in) disable iff (1'b0)
		rst_in && !$past(rst_in)
		|=> st_q.pe_latch == $past(st_q.pe_latch))
		else $error("reset changed port E latch");

	AST_PC_DIR_READ: assert property (
		setup_w && idx_w == ppr_pkg::IDX_PC_DIR
		|=> prdata_out == {25'h0000000, $past(st_q.pc_dir)})
		else $error("port C direction read wrong");

	AST_PE_LATCH_READ: assert property (
		setup_w && idx_w == ppr_pkg::IDX_PE_LATCH
		|=> prdata_out[ppr_pkg::DATA_W-1:ppr_pkg::PE_W] == '0)
		else $error("port E latch unused bits not zero");

	AST_PE_DIR_READ: assert property (
		setup_w && idx_w == ppr_pkg::IDX_PE_DIR
		|=> prdata_out == {30'h00000000, $past(st_q.pe_dir)})
		else $error("port E direction read wrong");

	AST_PC_PUE_READ: assert property (
		setup_w && idx_w == ppr_pkg::IDX_PC_PUE
		|=> prdata_out == {25'h0000000, $past(st_q.pc_pue)})
		else $error("port C pullup enable read wrong");

	AST_PD_DIR_READ: assert property (
		setup_w && idx_w == ppr_pkg::IDX_PD_DIR
		|=> prdata_out == {24'h000000, $past(st_q.pd_dir)})
		else $error("port D direction read wrong");

	AST_PD_PUE_READ: assert property (
		setup_w && idx_w == ppr_pkg::IDX_PD_PUE
		|=> prdata_out == {24'h000000, $past(st_q.pd_pue)})
		else $error("port D pullup enable read wrong");

	AST_PA_PUE_READ: assert property (
		setup_w && idx_w == ppr_pkg::IDX_PA_PUE
		|=> prdata_out == {24'h000000, $past(st_q.pa_pue)})
		else $error("port A pullup enable read wrong");

	AST_INPUT_NOT_DRIVEN: assert property (
		wr_w && idx_w == ppr_pkg::IDX_PA_LATCH
		|=> ##1 (pa_pin_out & ~st_q.pa_dir) == 8'h00)
		else $error("latch write drove an input pin");

	AST_PA_OUT_MASKED: assert property (
		(pa_pin_out & ~pa_pin_oe_out)
		== 8'h00)
		else $error("port A drive value on a disabled pin");

	AST_KBI_FORCES_INPUT: assert property (
		(pa_pin_oe_out & st_q.kbi_en)
		== 8'h00)
		else $error("keypad pin still driven");

	AST_PCD_PULLUP: assert property (
		pd_pullup_out == (st_q.pd_pue & ~st_q.pd_dir) &&
		pc_pullup_out == (st_q.pc_pue & ~st_q.pc_dir))
		else $error("port C or D pullup control wrong");

	AST_PE_PORT_OWN: assert property (
		!pe_periph_en_in
		|=> pe_pin_oe_out == st_q.pe_dir)
		else $error("port E drive does not follow direction");

	AST_UNMAPPED_ERR: assert property (
		setup_w && !hit
		|=> pslverr_out && pready_out && prdata_out == '0)
		else $error("unmapped access not refused");

	AST_ERR_NEEDS_READY: assert property (
		pslverr_out
		|-> pready_out)
		else $error("apb error without ready");

	AST_NO_READY_IDLE: assert property (
		!setup_w
		|=> !pready_out)
		else $error("apb ready without setup");

	AST_PRDATA_HOLD: assert property (
		!setup_w
		|=> $stable(prdata_out))
		else $error("apb read data changed outside setup");

endmodule // ppr_top

// ==== src/ppr_pkg.sv ====
package ppr_pkg;
	// register indexes; byte address is four times the index
	localparam logic [7:0] IDX_PA_LATCH = 8'h00;
	localparam logic [7:0] IDX_PC_DIR   = 8'h06;
	localparam logic [7:0] IDX_PD_DIR   = 8'h07;
	localparam logic [7:0] IDX_PE_LATCH = 8'h08;
	localparam logic [7:0] IDX_PE_DIR   = 8'h0C;
	localparam logic [7:0] IDX_PA_PUE   = 8'h0D;
	localparam logic [7:0] IDX_PC_PUE   = 8'h0E;
	localparam logic [7:0] IDX_PD_PUE   = 8'h0F;
	localparam logic [7:0] IDX_PA_DIR   = 8'h10;
	localparam logic [7:0] IDX_KBI_CTL  = 8'h11;

	// widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int PA_W   = 8;
	localparam int PC_W   = 7;
	localparam int PD_W   = 8;
	localparam int PE_W   = 2;

	// reset values
	localparam logic [7:0] DIR_RST = 8'h00;
	localparam logic [7:0] PUE_RST = 8'h00;
	localparam logic [7:0] KBI_RST = 8'h00;

	// word alignment of the apb address
	localparam int WORD_SHIFT = 2;

	// all state of the port block
	typedef struct packed {
		logic [PA_W-1:0]   pa_latch;
		logic [PA_W-1:0]   pa_dir;
		logic [PA_W-1:0]   pa_pue;
		logic [PA_W-1:0]   kbi_en;
		logic [PC_W-1:0]   pc_dir;
		logic [PC_W-1:0]   pc_pue;
		logic [PD_W-1:0]   pd_dir;
		logic [PD_W-1:0]   pd_pue;
		logic [PE_W-1:0]   pe_latch;
		logic [PE_W-1:0]   pe_dir;
		logic [PA_W-1:0]   pa_smp;
		logic [PE_W-1:0]   pe_smp;
		logic [PA_W-1:0]   pa_oe;
		logic [PA_W-1:0]   pa_do;
		logic [PA_W-1:0]   pa_pu;
		logic [PA_W-1:0]   kbd;
		logic [PC_W-1:0]   pc_pu;
		logic [PD_W-1:0]   pd_pu;
		logic [PE_W-1:0]   pe_oe;
		logic [PE_W-1:0]   pe_do;
		logic [DATA_W-1:0] prdata;
		logic              pready;
		logic              pslverr;
	} ppr_state_t;
endpackage

// ==== dv/ppr_board.sv ====
`timescale 1ns/10ps
// board side of port A: external drivers, pullups, floating lines
module ppr_board (
	// clock
	input  wire logic       clk_in,
	// device pad controls
	input  wire logic [7:0] oe_in,
	input  wire logic [7:0] drv_in,
	input  wire logic [7:0] pullup_in,
	// board drivers
	input  wire logic [7:0] ext_en_in,
	input  wire logic [7:0] ext_val_in,
	// resolved pin level
	output logic      [7:0] level_out
);
	logic [7:0] flt_q = 8'h55;
	// floating lines toggle so no stale level is ever seen
	always @(posedge clk_in) begin
		flt_q <= ~flt_q;
	end
	// wire level: device drive, then board, then pullup, else floating
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			level_out[i] = oe_in[i] ? drv_in[i] : ext_en_in[i] ? ext_val_in[i] :
				pullup_in[i] ? 1'b1 : flt_q[i];
		end
	end
endmodule // ppr_board

// ==== dv/testbench.sv ====
`timescale 1ns/10ps
module testbench;
	logic        clk_in = 1'b0, rst_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0;
	logic        pwrite_in = 1'b0, pready_out, pslverr_out, err, pe_pen = 1'b0;
	logic [7:0]  paddr_in = 8'h00, pa_pin, pa_do, pa_oe, pa_pu, kbd, pd_dir, pd_pu;
	logic [7:0]  ext_en = 8'h00, ext_val = 8'h00;
	logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
	logic [6:0]  pc_dir, pc_pu;
	logic [1:0]  pe_pin = 2'h1, pe_do, pe_oe, pe_poe = 2'h0, pe_pdo = 2'h0;
	int          err_count = 0, cmp_count = 0, cyc = 0;
	// 200 MHz clock and hang guard
	always #2.5 clk_in = ~clk_in;
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_count++;
			test_done();
		end
	end
	ppr_top i_ppr_top (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in),
		.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
		.pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
		.pslverr_out(pslverr_out), .pa_pin_in(pa_pin), .pa_pin_out(pa_do),
		.pa_pin_oe_out(pa_oe), .pa_pullup_out(pa_pu), .keypad_inputs_out(kbd),
		.pc_dir_out(pc_dir), .pc_pullup_out(pc_pu), .pd_dir_out(pd_dir),
		.pd_pullup_out(pd_pu), .pe_pin_in(pe_pin), .pe_pin_out(pe_do),
		.pe_pin_oe_out(pe_oe), .pe_periph_en_in(pe_pen), .pe_periph_oe_in(pe_poe),
		.pe_periph_do_in(pe_pdo));
	ppr_board i_ppr_board (.clk_in(clk_in), .oe_in(pa_oe), .drv_in(pa_do),
		.pullup_in(pa_pu), .ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(pa_pin));
	// compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one apb transfer, held until pready
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
		@(posedge clk_in);
		psel_in    <= 1'b1;
		penable_in <= 1'b0;
		pwrite_in  <= wr;
		paddr_in   <= idx << 2;
		pwdata_in  <= wd;
		@(posedge clk_in);
		penable_in <= 1'b1;
		do @(posedge clk_in); while (pready_out !== 1'b1);
		rd  = prdata_out;
		err = pslverr_out;
		psel_in    <= 1'b0;
		penable_in <= 1'b0;
	endtask
	task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0);
		chk(rd, exp);
		chk(err, 1'b0);
	endtask
	task automatic wrchk(input logic [7:0] idx, input logic [31:0] wd, input logic [31:0] exp);
		apb(1'b1, idx, wd);
		rdchk(idx, exp);
	endtask
	// reset values and unmapped access
	task automatic t_reset();
		rdchk(ppr_pkg::IDX_PA_DIR, 8'h00);
		rdchk(ppr_pkg::IDX_PC_DIR, 8'h00);
		rdchk(ppr_pkg::IDX_PD_DIR, 8'h00);
		rdchk(ppr_pkg::IDX_PE_DIR, 8'h00);
		rdchk(ppr_pkg::IDX_PA_PUE, 8'h00);
		rdchk(ppr_pkg::IDX_PC_PUE, 8'h00);
		rdchk(ppr_pkg::IDX_PD_PUE, 8'h00);
		chk(pa_oe, 8'h00);
		apb(1'b1, 8'h3F, 32'hFF);
		chk(err, 1'b1);
		$display("test reset done");
	endtask
	// implemented bits and read-as-zero bits
	task automatic t_widths();
		wrchk(ppr_pkg::IDX_PC_DIR, 32'hFF, 8'h7F);
		wrchk(ppr_pkg::IDX_PD_DIR, 32'hFF, 8'hFF);
		wrchk(ppr_pkg::IDX_PE_DIR, 32'hFF, 8'h03);
		wrchk(ppr_pkg::IDX_PE_LATCH, 32'hFF, 8'h03);
		wrchk(ppr_pkg::IDX_PA_PUE, 32'hFF, 8'hFF);
		wrchk(ppr_pkg::IDX_PC_PUE, 32'hFF, 8'h7F);
		wrchk(ppr_pkg::IDX_PD_PUE, 32'hFF, 8'hFF);
		chk(pc_dir, 7'h7F);
		chk(pd_dir, 8'hFF);
		chk(pc_pu, 7'h00);
		chk(pd_pu, 8'h00);
		$display("test widths done");
	endtask
	// latch, direction, pullup and keypad sharing on port A
	task automatic t_port_a();
		ext_en  <= 8'hFF;
		ext_val <= 8'h3C;
		apb(1'b1, ppr_pkg::IDX_PA_LATCH, 32'hA5);
		rdchk(ppr_pkg::IDX_PA_LATCH, 8'h3C);
		ext_en <= 8'hF0;
		apb(1'b1, ppr_pkg::IDX_PA_DIR, 32'h0F);
		repeat (3) @(posedge clk_in);
		chk(pa_oe, 8'h0F);
		chk(pa_do, 8'h05);
		chk(pa_pu, 8'hF0);
		rdchk(ppr_pkg::IDX_PA_LATCH, 8'h35);
		apb(1'b1, ppr_pkg::IDX_KBI_CTL, 32'hC3);
		ext_en  <= 8'hF3;
		ext_val <= 8'hFF;
		repeat (4) @(posedge clk_in);
		chk(pa_oe, 8'h0C);
		chk(kbd, 8'hC3);
		apb(1'b1, ppr_pkg::IDX_KBI_CTL, 32'h00);
		$display("test port a done");
	endtask
	// reset in mid-run keeps data latches
	task automatic t_reset_mid();
		@(posedge clk_in);
		rst_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		rst_in <= 1'b0;
		ext_en <= 8'h00;
		@(posedge clk_in);
		chk(pa_oe, 8'h00);
		apb(1'b1, ppr_pkg::IDX_PA_DIR, 32'hFF);
		rdchk(ppr_pkg::IDX_PA_LATCH, 8'hA5);
		rdchk(ppr_pkg::IDX_PE_LATCH, 8'h01);
		apb(1'b1, ppr_pkg::IDX_PE_DIR, 32'h03);
		rdchk(ppr_pkg::IDX_PE_LATCH, 8'h03);
		$display("test reset mid done");
	endtask
	// sharing peripheral takes port E pins
	task automatic t_pe_periph();
		pe_pen <= 1'b1;
		pe_poe <= 2'h2;
		pe_pdo <= 2'h1;
		repeat (3) @(posedge clk_in);
		chk(pe_oe, 2'h2);
		chk(pe_do, 2'h1);
		pe_pen <= 1'b0;
		repeat (3) @(posedge clk_in);
		chk(pe_oe, 2'h3);
		chk(pe_do, 2'h3);
		$display("test port e done");
	endtask
	// verdict
	task automatic test_done();
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clk_in);
		rst_in <= 1'b0;
		t_reset();
		t_widths();
		t_port_a();
		t_reset_mid();
		t_pe_periph();
		test_done();
	end
endmodule // testbench
